// ==== board_model.sv ====
// board_model.sv - board side of the shared pins and the gated reference clock
// assumes: pins settle at once; pull_low is the far side's own clock request
`timescale 1ns/10ps

module board_model (
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pull_low,
   output logic      [2:0] pin_level,
   output logic      [2:0] refclk_on
);
   // released lines go to the pull-up; any driver low wins
   assign pin_level = (~pin_oe | pin_out) & ~pull_low;
   // clock stops while nobody requests it, restarts when anyone does
   assign refclk_on = ~pin_level;
endmodule : board_model

// ==== clkreq_fsm.sv ====
// clkreq_fsm.sv - one l1 substate clock request sequencer per port
// assumes: pin_low is already synchronised; clk_en freezes state
`timescale 1ns/10ps
`include "port_cfg_consts.svh"

module clkreq_fsm (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   l1_ctrl_if.fsm    lc
);

   localparam port_cfg_pkg::cnt_t SETTLE = port_cfg_pkg::cnt_t'(`REFCLK_SETTLE_CYC);

   // ****************************************
   // per port sequencers
   // ****************************************
   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_port
         port_cfg_pkg::l1_state_e state;
         port_cfg_pkg::l1_state_e next_state;
         port_cfg_pkg::cnt_t      cnt;

         always_comb begin
            next_state = state;
            case (state)
               port_cfg_pkg::ST_ACTIVE: begin
                  if (lc.substate_mode && lc.l1_req[p] && lc.l1_allow[p]) begin
                     next_state = port_cfg_pkg::ST_ENTRY;
                  end
               end
               port_cfg_pkg::ST_ENTRY: begin
                  // the partner may keep the clock alive by holding the line low
                  if (!lc.l1_req[p] || !lc.substate_mode) begin
                     next_state = port_cfg_pkg::ST_ACTIVE;
                  end else if (!lc.pin_low[p]) begin
                     next_state = port_cfg_pkg::ST_SUBSTATE;
                  end
               end
               port_cfg_pkg::ST_SUBSTATE: begin
                  if (lc.pin_low[p] || !lc.l1_req[p] || !lc.substate_mode) begin
                     next_state = port_cfg_pkg::ST_WAKE;
                  end
               end
               port_cfg_pkg::ST_WAKE: begin
                  if (cnt == SETTLE) begin
                     next_state = port_cfg_pkg::ST_ACTIVE;
                  end
               end
               default: next_state = port_cfg_pkg::ST_ACTIVE;
            endcase
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               state <= port_cfg_pkg::ST_ACTIVE;
            end else if (clk_en) begin
               state <= next_state;
            end
         end

         // wait for the reference clock to settle before the pll is trusted
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               cnt <= '0;
            end else if (clk_en) begin
               if (state == port_cfg_pkg::ST_WAKE) begin
                  cnt <= cnt + port_cfg_pkg::cnt_t'(1);
               end else begin
                  cnt <= '0;
               end
            end
         end

         assign lc.drive_req[p]   = (state == port_cfg_pkg::ST_ACTIVE) ||
                                    (state == port_cfg_pkg::ST_WAKE);
         assign lc.pll_en[p]      = (state == port_cfg_pkg::ST_ACTIVE) ||
                                    (state == port_cfg_pkg::ST_ENTRY);
         assign lc.in_substate[p] = (state == port_cfg_pkg::ST_SUBSTATE);
      end
   endgenerate

endmodule : clkreq_fsm

// ==== l1_ctrl_if.sv ====
// l1_ctrl_if.sv - per port clock request handshake between decoder and fsm
// assumes: one clock domain, all signals on clk
`timescale 1ns/10ps

interface l1_ctrl_if;
   port_cfg_pkg::port_vec_t l1_req;
   port_cfg_pkg::port_vec_t l1_allow;
   logic                    substate_mode;
   port_cfg_pkg::port_vec_t pin_low;
   port_cfg_pkg::port_vec_t drive_req;
   port_cfg_pkg::port_vec_t pll_en;
   port_cfg_pkg::port_vec_t in_substate;

   modport ctrl (
      output l1_req,
      output l1_allow,
      output substate_mode,
      output pin_low,
      input  drive_req,
      input  pll_en,
      input  in_substate
   );

   modport fsm (
      input  l1_req,
      input  l1_allow,
      input  substate_mode,
      input  pin_low,
      output drive_req,
      output pll_en,
      output in_substate
   );
endinterface : l1_ctrl_if

// ==== port_cfg_consts.svh ====
// port_cfg_consts.svh - offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the design modules
`ifndef PORT_CFG_CONSTS_SVH
`define PORT_CFG_CONSTS_SVH

// ****************************************
// clock and timing
// ****************************************
`define CLK_MHZ             50
`define REFCLK_SETTLE_NS    400
`define REFCLK_SETTLE_CYC   ((`REFCLK_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_STAGES         2
`define CNT_W               8

// ****************************************
// register offsets
// ****************************************
`define ADDR_W              8
`define REG_CONFIG          8'h00
`define REG_CONTROL         8'h04
`define REG_L1_STATUS       8'h08

// ****************************************
// config register fields
// ****************************************
`define CFG_SECOND_CHANNEL_ENABLE          0
`define CFG_VC_SHARE        1
`define CFG_POLDET_EN       2
`define CFG_PAYLOAD_LSB     3
`define CFG_PRESENT_LSB     6
`define CFG_COMMON_CLK      8
`define CFG_SLOT_LSB        9
`define CFG_STATUS_MODE     11
`define CFG_VALID           12

// ****************************************
// control and l1 status fields
// ****************************************
`define CTL_L1_ALLOW_LSB    0
`define CTL_RESET           3'h0
`define L1S_PLL_LSB         0
`define L1S_SUB_LSB         3
`define L1S_PIN_LSB         6

// ****************************************
// payload capability encodings
// ****************************************
`define PAYLOAD_256         3'h1
`define PAYLOAD_512         3'h2

`endif

// ==== port_cfg_pkg.sv ====
// port_cfg_pkg.sv - types shared by the strap decoder and the clock request fsm
// assumes: port_cfg_consts.svh is on the include path
`include "port_cfg_consts.svh"

package port_cfg_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      ST_ACTIVE,
      ST_ENTRY,
      ST_SUBSTATE,
      ST_WAKE
   } l1_state_e;

   typedef logic [`CNT_W-1:0] cnt_t;
   typedef logic [2:0]        port_vec_t;

endpackage : port_cfg_pkg

// ==== port_config_strap_decode.sv ====
// port_config_strap_decode.sv - board strap decoder and shared clock request pins
// assumes: straps and shared pins are asynchronous; core signals are on clk
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "port_cfg_consts.svh"

module port_config_strap_decode (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        second_channel_enable,
   input  wire logic        rx_polarity_detect_disable,
   input  wire logic        large_payload_strap,
   input  wire logic [2:1]  slot_presence_n,
   input  wire logic        common_refclk_strap,
   input  wire logic [2:1]  slot_implemented_strap,
   input  wire logic        substate_or_status_select,
   input  wire logic [2:0]  shared_pin_in,
   output logic      [2:0]  shared_pin_out,
   output logic      [2:0]  shared_pin_oe,
   input  wire logic [2:0]  port_link_up,
   input  wire logic [2:0]  l1_entry_req,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             config_valid,
   output logic             vc1_enable,
   output logic             vc_resource_share,
   output logic             rx_polarity_detect_en,
   output logic      [2:0]  max_payload_supported,
   output logic      [2:1]  port_present,
   output logic             common_refclk_config,
   output logic      [2:1]  slot_connected,
   output logic             status_mode,
   output logic      [2:0]  pll_enable,
   output logic      [2:0]  l1_substate_active
);

   localparam int STRAP_W = 9;

   // ****************************************
   // synchronisers
   // ****************************************
   logic [STRAP_W-1:0] strap_meta;
   logic [STRAP_W-1:0] strap_sync;
   logic [2:0]         pin_meta;
   logic [2:0]         pin_sync;
   logic [STRAP_W-1:0] strap_raw;

   assign strap_raw = {substate_or_status_select, slot_implemented_strap,
                       common_refclk_strap, slot_presence_n, large_payload_strap,
                       rx_polarity_detect_disable, second_channel_enable};

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_meta <= '0;
         strap_sync <= '0;
      end else if (clk_en) begin
         strap_meta <= strap_raw;
         strap_sync <= strap_meta;
      end
   end

   // idle shared line is high, so the synchroniser resets high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= 3'h7;
         pin_sync <= 3'h7;
      end else if (clk_en) begin
         pin_meta <= shared_pin_in;
         pin_sync <= pin_meta;
      end
   end

   // ****************************************
   // strap capture after reset release
   // ****************************************
   logic [1:0]         cap_cnt;
   logic [STRAP_W-1:0] strap_hold;

   // capture waits for the synchroniser to fill with post-reset values
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cap_cnt      <= 2'h0;
         config_valid <= 1'b0;
         strap_hold   <= '0;
      end else if (clk_en && !config_valid) begin
         if (cap_cnt == 2'(`SYNC_STAGES)) begin
            strap_hold   <= strap_sync;
            config_valid <= 1'b1;
         end else begin
            cap_cnt <= cap_cnt + 2'h1;
         end
      end
   end

   // ****************************************
   // decode
   // ****************************************
   logic s_vc1;
   logic s_poldis;
   logic s_pl512;
   logic s_common;
   logic s_select;
   logic [2:1] s_slot_presence_n_n;
   logic [2:1] s_slot;

   assign s_vc1     = strap_hold[0];
   assign s_poldis  = strap_hold[1];
   assign s_pl512   = strap_hold[2];
   assign s_slot_presence_n_n = strap_hold[4:3];
   assign s_common  = strap_hold[5];
   assign s_slot    = strap_hold[7:6];
   assign s_select  = strap_hold[8];

   // decoded values only change at capture, so they stay stable until reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         vc1_enable            <= 1'b0;
         vc_resource_share     <= 1'b0;
         rx_polarity_detect_en <= 1'b0;
         max_payload_supported <= `PAYLOAD_256;
         port_present          <= 2'h0;
         common_refclk_config  <= 1'b0;
         slot_connected        <= 2'h0;
         status_mode           <= 1'b0;
      end else if (clk_en) begin
         vc1_enable            <= config_valid & s_vc1;
         vc_resource_share     <= config_valid & ~s_vc1;
         rx_polarity_detect_en <= config_valid & ~s_poldis;
         max_payload_supported <= s_pl512 ? `PAYLOAD_512 : `PAYLOAD_256;
         port_present          <= config_valid ? ~s_slot_presence_n_n : 2'h0;
         common_refclk_config  <= config_valid & s_common;
         slot_connected        <= config_valid ? s_slot : 2'h0;
         status_mode           <= config_valid & s_select;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   logic [2:0] l1_allow;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         l1_allow <= `CTL_RESET;
      end else if (clk_en && reg_wr && reg_addr == `REG_CONTROL) begin
         l1_allow <= reg_wdata[`CTL_L1_ALLOW_LSB +: 3];
      end
   end

   function automatic logic [31:0] read_mux(input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0;
      case (a)
         `REG_CONFIG: begin
            d[`CFG_SECOND_CHANNEL_ENABLE]                = vc1_enable;
            d[`CFG_VC_SHARE]              = vc_resource_share;
            d[`CFG_POLDET_EN]             = rx_polarity_detect_en;
            d[`CFG_PAYLOAD_LSB +: 3]      = max_payload_supported;
            d[`CFG_PRESENT_LSB +: 2]      = port_present;
            d[`CFG_COMMON_CLK]            = common_refclk_config;
            d[`CFG_SLOT_LSB +: 2]         = slot_connected;
            d[`CFG_STATUS_MODE]           = status_mode;
            d[`CFG_VALID]                 = config_valid;
         end
         `REG_CONTROL: d[`CTL_L1_ALLOW_LSB +: 3] = l1_allow;
         `REG_L1_STATUS: begin
            d[`L1S_PLL_LSB +: 3]          = pll_enable;
            d[`L1S_SUB_LSB +: 3]          = l1_substate_active;
            d[`L1S_PIN_LSB +: 3]          = pin_sync;
         end
         default: d = 32'h0;
      endcase
      return d;
   endfunction : read_mux

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h0;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? read_mux(reg_addr) : 32'h0;
      end
   end

   // ****************************************
   // clock request sequencing
   // ****************************************
   l1_ctrl_if lc ();

   assign lc.l1_req        = l1_entry_req;
   assign lc.l1_allow      = l1_allow;
   // held strap, not status_mode, so no request cycle slips in before status_mode sets
   assign lc.substate_mode = config_valid & ~s_select;
   assign lc.pin_low       = ~pin_sync;

   clkreq_fsm u_fsm (
      .clk    (clk),
      .nrst   (nrst),
      .clk_en (clk_en),
      .lc     (lc)
   );

   assign pll_enable         = lc.pll_en;
   assign l1_substate_active = lc.in_substate;

   // ****************************************
   // shared pins
   // ****************************************
   logic [2:0] port_state_out;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_state_out <= 3'h0;
      end else if (clk_en) begin
         port_state_out <= port_link_up;
      end
   end

   // clock request is open drain: drive low to assert, release to deassert
   // pins stay released until the select strap has been captured
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shared_pin_out <= 3'h0;
         shared_pin_oe  <= 3'h0;
      end else if (clk_en) begin
         if (status_mode) begin
            shared_pin_out <= port_state_out;
            shared_pin_oe  <= 3'h7;
         end else if (config_valid && !s_select) begin
            shared_pin_out <= 3'h0;
            shared_pin_oe  <= lc.drive_req;
         end else begin
            shared_pin_out <= 3'h0;
            shared_pin_oe  <= 3'h0;
         end
      end
   end

endmodule : port_config_strap_decode

// ==== port_config_strap_decode_tb.sv ====
// port_config_strap_decode_tb.sv - self-checking bench for the strap decoder
// assumes: design, board_model and strap_decode_sva compiled first
`timescale 1ns/10ps
`include "port_cfg_consts.svh"

module port_config_strap_decode_tb;
   // ****************************************
   // signals
   // ****************************************
   logic        clk, nrst, clk_en, reg_wr, reg_rd, rd_seen, config_valid, status_mode;
   logic        second_channel_enable, rx_polarity_detect_disable, large_payload_strap;
   logic        common_refclk_strap, substate_or_status_select, vc1_enable;
   logic        vc_resource_share, rx_polarity_detect_en, common_refclk_config;
   logic [2:1]  slot_presence_n, slot_implemented_strap, port_present, slot_connected;
   logic [2:0]  shared_pin_in, shared_pin_out, shared_pin_oe, port_link_up, l1_entry_req;
   logic [2:0]  pull_low, refclk_on, max_payload_supported, pll_enable, l1_substate_active;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, exp_cfg, r;
   logic [31:0] exp_q[$];
   int          error_cnt, checks, cyc, n;

   port_config_strap_decode dut_u (.clk, .nrst, .clk_en, .second_channel_enable,
      .rx_polarity_detect_disable, .large_payload_strap, .slot_presence_n,
      .common_refclk_strap, .slot_implemented_strap, .substate_or_status_select,
      .shared_pin_in, .shared_pin_out, .shared_pin_oe, .port_link_up, .l1_entry_req,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .config_valid, .vc1_enable,
      .vc_resource_share, .rx_polarity_detect_en, .max_payload_supported, .port_present,
      .common_refclk_config, .slot_connected, .status_mode, .pll_enable, .l1_substate_active);
   board_model board_u (.pin_oe(shared_pin_oe), .pin_out(shared_pin_out), .pull_low,
      .pin_level(shared_pin_in), .refclk_on);

   // ****************************************
   // helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   // strobes stay up between back-to-back cycles; bus_idle drops them
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : reg_read

   task automatic bus_idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : bus_idle

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (10) @(posedge clk);
   endtask : do_reset

   // config word expected from the straps now applied
   function automatic logic [31:0] cfg_word();
      cfg_word = 32'h0;
      cfg_word[`CFG_SECOND_CHANNEL_ENABLE] = second_channel_enable;
      cfg_word[`CFG_VC_SHARE] = ~second_channel_enable;
      cfg_word[`CFG_POLDET_EN] = ~rx_polarity_detect_disable;
      cfg_word[`CFG_PAYLOAD_LSB +: 3] = large_payload_strap ? `PAYLOAD_512 : `PAYLOAD_256;
      cfg_word[`CFG_PRESENT_LSB +: 2] = ~slot_presence_n;
      cfg_word[`CFG_COMMON_CLK] = common_refclk_strap;
      cfg_word[`CFG_SLOT_LSB +: 2] = slot_implemented_strap;
      cfg_word[`CFG_STATUS_MODE] = substate_or_status_select;
      cfg_word[`CFG_VALID] = 1'b1;
   endfunction : cfg_word

   function automatic logic [31:0] port_word();
      port_word = {19'h0, config_valid, status_mode, slot_connected, common_refclk_config,
         port_present, max_payload_supported, rx_polarity_detect_en, vc_resource_share,
         vc1_enable};
   endfunction : port_word

   // ****************************************
   // monitor and timeout
   // ****************************************
   always @(posedge clk) rd_seen <= reg_rd & clk_en;
   always @(negedge clk) if (rd_seen) check(reg_rdata, exp_q.pop_front(), "read data");

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ****************************************
   // stimulus
   // ****************************************
   initial begin
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, port_link_up, l1_entry_req, pull_low} = '0;
      {second_channel_enable, rx_polarity_detect_disable, large_payload_strap} = '0;
      {slot_presence_n, common_refclk_strap, slot_implemented_strap} = '0;
      substate_or_status_select = 1'b0;
      clk_en = 1'b1;
      void'($urandom(32'h86a8));
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         {rx_polarity_detect_disable, common_refclk_strap} <= r[1:0];
         {slot_presence_n, slot_implemented_strap} <= r[5:2];
         {second_channel_enable, large_payload_strap} <= 2'(i);
         do_reset();
         exp_cfg = cfg_word();
         check(port_word(), exp_cfg, "decoded");
         check({shared_pin_oe, shared_pin_out}, 6'h38, "request idle");
         reg_read(`REG_CONFIG, exp_cfg);
         reg_read(`REG_L1_STATUS, 32'h7);
         bus_idle();
         {second_channel_enable, large_payload_strap, slot_presence_n} <= ~r[9:6];
         repeat (6) @(posedge clk);
         check(port_word(), exp_cfg, "held");
      end
      reg_read(`REG_CONTROL, 32'h0);
      reg_write(`REG_CONTROL, 32'hffff_fffd);
      reg_write(`REG_CONFIG, 32'h0);
      reg_read(`REG_CONTROL, 32'h5);
      reg_read(`REG_CONFIG, exp_cfg);
      reg_read(8'h0c, 32'h0);
      bus_idle();
      clk_en <= 1'b0;
      reg_write(`REG_CONTROL, 32'h2);
      clk_en <= 1'b1;
      bus_idle();
      reg_read(`REG_CONTROL, 32'h5);
      bus_idle();
      // port 1 asks too but its allow bit is clear
      l1_entry_req <= 3'h3;
      n = 0;
      while (l1_substate_active[0] !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check({pll_enable, l1_substate_active, refclk_on}, 9'o616, "asleep");
      @(posedge clk);
      reg_read(`REG_L1_STATUS, 32'h4e);
      bus_idle();
      pull_low <= 3'h1;
      l1_entry_req <= 3'h2;
      n = 0;
      while (pll_enable[0] !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      check(32'(n >= `REFCLK_SETTLE_CYC && n < 40), 32'h1, "wake delay");
      check({shared_pin_oe[0], refclk_on[0]}, 32'h3, "awake");
      @(posedge clk);
      pull_low <= 3'h0;
      l1_entry_req <= 3'h7;
      substate_or_status_select <= 1'b1;
      do_reset();
      reg_read(`REG_CONFIG, cfg_word());
      reg_read(`REG_CONTROL, 32'h0);
      bus_idle();
      for (int k = 0; k < 6; k++) begin
         port_link_up <= 3'($urandom);
         repeat (3) @(negedge clk);
         r = {3'h7, port_link_up};
         check({shared_pin_oe, shared_pin_out}, r, "status pins");
         @(posedge clk);
      end
      wrap_up();
   end
endmodule : port_config_strap_decode_tb

bind port_config_strap_decode strap_decode_sva chk_u (.clk, .nrst, .clk_en, .config_valid,
   .vc1_enable, .vc_resource_share, .rx_polarity_detect_en, .max_payload_supported,
   .port_present, .common_refclk_config, .slot_connected, .status_mode, .shared_pin_out,
   .shared_pin_oe, .port_link_up, .pll_enable, .l1_substate_active);

// ==== strap_decode_sva.sv ====
// strap_decode_sva.sv - port level assertions for the strap decoder
// assumes: bound to port_config_strap_decode; one clock, nrst async active low
`timescale 1ns/10ps
`include "port_cfg_consts.svh"

module strap_decode_sva (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       clk_en,
   input wire logic       config_valid,
   input wire logic       vc1_enable,
   input wire logic       vc_resource_share,
   input wire logic       rx_polarity_detect_en,
   input wire logic [2:0] max_payload_supported,
   input wire logic [2:1] port_present,
   input wire logic       common_refclk_config,
   input wire logic [2:1] slot_connected,
   input wire logic       status_mode,
   input wire logic [2:0] shared_pin_out,
   input wire logic [2:0] shared_pin_oe,
   input wire logic [2:0] port_link_up,
   input wire logic [2:0] pll_enable,
   input wire logic [2:0] l1_substate_active
);
   // ****************************************
   // assertions
   // ****************************************
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!nrst);

   // one vector so a single stability check covers every decoded strap
   wire logic [11:0] decoded = {vc1_enable, vc_resource_share, rx_polarity_detect_en,
      max_payload_supported, port_present, common_refclk_config, slot_connected, status_mode};

   // counts enabled wake cycles of port 0: pll off while out of the substate
   logic [7:0] wake_cnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_cnt <= 8'h0;
      end else if (clk_en) begin
         if (!pll_enable[0] && !l1_substate_active[0]) begin
            wake_cnt <= wake_cnt + 8'h1;
         end else begin
            wake_cnt <= 8'h0;
         end
      end
   end

   chk_vc_exclusive: assert property (
      config_valid && $past(config_valid) |-> vc_resource_share == !vc1_enable)
      else $error("vc1 and sharing not exclusive");
   chk_payload_code: assert property (
      max_payload_supported != `PAYLOAD_256 |->
         config_valid && max_payload_supported == `PAYLOAD_512)
      else $error("bad payload capability code");
   chk_cfg_hold: assert property (
      config_valid && $past(config_valid, 2) |-> $stable(decoded))
      else $error("decoded straps changed after capture");
   chk_req_out_low: assert property (
      !status_mode && $past(config_valid, 2) |-> shared_pin_out == 3'h0)
      else $error("clock request pin driven high");
   chk_status_oe: assert property (
      status_mode && $past(status_mode, 2) |-> shared_pin_oe == 3'h7)
      else $error("status pins not driven");
   chk_status_value: assert property (
      status_mode && $past(status_mode, 3) |-> shared_pin_out == $past(port_link_up, 2))
      else $error("status pin value wrong");
   chk_pll_substate: assert property (
      (l1_substate_active & pll_enable) == 3'h0)
      else $error("pll on inside substate");
   chk_line_released: assert property (
      (l1_substate_active & shared_pin_oe) == 3'h0)
      else $error("request line held in substate");
   chk_wake_settle: assert property (
      $rose(pll_enable[0]) |-> wake_cnt == 8'(`REFCLK_SETTLE_CYC + 1))
      else $error("pll wake timing wrong");
   chk_reset_state: assert property (@(posedge clk) disable iff (1'b0)
      !nrst |-> shared_pin_oe == 3'h0 && !config_valid && pll_enable == 3'h7)
      else $error("reset state wrong");

   cover property (config_valid && vc1_enable);
   cover property (status_mode && shared_pin_out != 3'h0);
   cover property ($fell(l1_substate_active[0]));
endmodule : strap_decode_sva
